// ==== core/pcsia_pkg.sv ====
package pcsia_pkg;

  // Widths.
  localparam int PC_W     = 13;
  localparam int TGT_W    = 11;
  localparam int BYTE_W   = 8;
  localparam int DADDR_W  = 9;
  localparam int STACK_N  = 8;
  localparam int SP_W     = 3;
  localparam int WB_AW    = 8;

  // Register byte offsets on the bus.
  localparam logic [WB_AW-1:0] OFF_INDIRECT_DATA_PORT  = 8'h00;
  localparam logic [WB_AW-1:0] OFF_PROG_COUNT_LOW      = 8'h04;
  localparam logic [WB_AW-1:0] OFF_FILE_SELECT_POINTER = 8'h08;
  localparam logic [WB_AW-1:0] OFF_PROG_COUNT_HIGH_HOLD = 8'h0c;
  localparam logic [WB_AW-1:0] OFF_BANK_SELECT         = 8'h10;

  // Pointer value that names the indirect data port itself.
  localparam logic [BYTE_W-1:0] INDIRECT_PORT_FILE_ADDR = 8'h00;

  // Field positions.
  localparam int BANK_BIT_POS  = 7;
  localparam int HOLD_CALL_LO  = 3;
  localparam int HOLD_CALL_HI  = 4;

  // Values after reset, and the default interrupt vector.
  localparam logic [PC_W-1:0]   PC_RESET    = 13'h0000;
  localparam logic [BYTE_W-1:0] HOLD_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] FSR_RESET   = 8'h00;
  localparam logic [SP_W-1:0]   SP_RESET    = 3'h0;
  localparam logic [PC_W-1:0]   IRQ_VECTOR_DEFAULT = 13'h0004;

  // Control-flow operations issued by the instruction decoder.
  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_NEXT   = 3'b001,
    OP_GOTO   = 3'b010,
    OP_CALL   = 3'b011,
    OP_RETURN = 3'b100,
    OP_RETURN_WITH_LITERAL  = 3'b101,
    OP_RETURN_FROM_INTERRUPT = 3'b110,
    OP_IRQ    = 3'b111
  } pcsia_op_t;

  typedef struct packed {
    logic             valid;
    pcsia_op_t        op;
    logic [TGT_W-1:0] target;
  } pcsia_ctl_t;

  typedef struct packed {
    logic               re;
    logic               we;
    logic [DADDR_W-1:0] addr;
    logic [BYTE_W-1:0]  wdata;
  } pcsia_mem_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_RD1   = 2'b01,
    BUS_RD2   = 2'b10
  } pcsia_bus_t;

endpackage

// ==== core/pcsia_core.sv ====
`timescale 1ns/10ps
// Summary of operation
// - The program counter is thirteen bits wide.
// - Low program-count register holds counter bits 7..0, readable and writable.
// - Counter bits 12..8 are not software visible; software loads them only from the holding latch.
// - Every reset clears the whole program counter to zero.
// - Writing the low register loads holding latch bits 4..0 into counter top.
// - Call or jump takes holding latch bits 4..3 into counter bits 12..11.
// - Return stack has eight 13-bit entries outside program and data space.
// - The return stack pointer cannot be read or written by software.
// - Call or interrupt vectoring pushes the program counter onto the stack.
// - Return, return with literal and return from interrupt pop the stack.
// - Pushes and pops leave the holding latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first entry.
// - Overflow and underflow are never reported; wrapping is silent.
// - The indirect data port has no storage; naming it starts indirect access.
// - Indirect access reaches the data location held in the file select pointer.
// - Indirect read through a pointer at the port itself returns zero.
// - Indirect write through a pointer at the port itself stores nothing.
// - Indirect address is a zero bit above the eight-bit file select pointer.
// - The bank bit has no effect on the indirect address used.
module pcsia_core #(
  parameter logic [pcsia_pkg::PC_W-1:0] IRQ_VECTOR = pcsia_pkg::IRQ_VECTOR_DEFAULT
) (
  // Clock and reset.
  input  wire logic                               clk,
  input  wire logic                               srst,
  // Wishbone slave.
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [pcsia_pkg::WB_AW-1:0]        wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [31:0]                        wb_dat_i,
  output logic      [31:0]                        wb_dat_o,
  output logic                                    wb_ack_o,
  // Instruction decoder.
  input  wire pcsia_pkg::pcsia_ctl_t              ctlReq,
  output logic      [pcsia_pkg::PC_W-1:0]         progCount,
  // Data memory.
  output pcsia_pkg::pcsia_mem_t                   memReq,
  input  wire logic [pcsia_pkg::BYTE_W-1:0]       memRdata
);

  localparam int PC_W   = pcsia_pkg::PC_W;
  localparam int BYTE_W = pcsia_pkg::BYTE_W;
  localparam int SP_W   = pcsia_pkg::SP_W;

  logic [PC_W-1:0]   pc_ff;
  logic [BYTE_W-1:0] hold_ff;
  logic [BYTE_W-1:0] fsr_ff;
  logic              bankBit_ff;
  logic [SP_W-1:0]   sp_ff;
  logic [PC_W-1:0]   stack_ff [pcsia_pkg::STACK_N];
  logic [31:0]       wbDat_ff;
  logic              wbAck_ff;
  logic              memRe_ff;
  logic              memWe_ff;
  logic [pcsia_pkg::DADDR_W-1:0] memAddr_ff;
  logic [BYTE_W-1:0] memWdata_ff;
  pcsia_pkg::pcsia_bus_t busState_ff;
  pcsia_pkg::pcsia_bus_t nxt_busState;
  logic [PC_W-1:0]   nxt_pc;
  logic [SP_W-1:0]   nxt_sp;

  // The return stack pointer has no bus address at all.
  logic              busReq;
  logic              startRd;
  logic              indHit;
  logic              take;
  logic              wrTake;
  logic              hitIndf;
  logic              hitPcl;
  logic              hitFsr;
  logic              hitHold;
  logic              hitBank;
  logic              ptrSelf;
  logic              doPush;
  logic              doPop;
  logic              pclWrite;
  logic [SP_W-1:0]   spPrev;
  logic [PC_W-1:0]   pushValue;
  logic [PC_W-1:0]   pcNext1;
  logic [pcsia_pkg::DADDR_W-1:0] indAddr;
  logic [31:0]       rdMux;

  assign progCount = pc_ff;
  assign wb_dat_o  = wbDat_ff;
  assign wb_ack_o  = wbAck_ff;
  assign memReq    = {memRe_ff, memWe_ff, memAddr_ff, memWdata_ff};

  // Address decode on the word address; the two low address bits select nothing.
  always_comb begin
    hitIndf = 1'b0;
    hitPcl  = 1'b0;
    hitFsr  = 1'b0;
    hitHold = 1'b0;
    hitBank = 1'b0;
    case (wb_adr_i[7:2])
      pcsia_pkg::OFF_INDIRECT_DATA_PORT[7:2]: begin
        hitIndf = 1'b1;
      end
      pcsia_pkg::OFF_PROG_COUNT_LOW[7:2]: begin
        hitPcl = 1'b1;
      end
      pcsia_pkg::OFF_FILE_SELECT_POINTER[7:2]: begin
        hitFsr = 1'b1;
      end
      pcsia_pkg::OFF_PROG_COUNT_HIGH_HOLD[7:2]: begin
        hitHold = 1'b1;
      end
      pcsia_pkg::OFF_BANK_SELECT[7:2]: begin
        hitBank = 1'b1;
      end
      default: begin
        hitIndf = 1'b0;
      end
    endcase
  end

  assign busReq = wb_cyc_i && wb_stb_i && !wbAck_ff && (busState_ff == pcsia_pkg::BUS_IDLE);

  // A low-register write waits while the decoder moves the counter itself.
  assign take     = busReq && !(wb_we_i && hitPcl && ctlReq.valid);
  assign wrTake   = take && wb_we_i && wb_sel_i[0];
  assign pclWrite = wrTake && hitPcl;

  assign ptrSelf = fsr_ff == pcsia_pkg::INDIRECT_PORT_FILE_ADDR;
  assign indAddr = {1'b0, fsr_ff};
  assign indHit  = take && hitIndf && !ptrSelf;

  // Only an indirect read through a real pointer needs the wait states.
  assign startRd = indHit && !wb_we_i;

  // Stack traffic decoded from the decoder operation.
  always_comb begin
    doPush = 1'b0;
    doPop  = 1'b0;
    if (ctlReq.valid) begin
      case (ctlReq.op)
        pcsia_pkg::OP_CALL, pcsia_pkg::OP_IRQ: begin
          doPush = 1'b1;
        end
        pcsia_pkg::OP_RETURN, pcsia_pkg::OP_RETURN_WITH_LITERAL, pcsia_pkg::OP_RETURN_FROM_INTERRUPT: begin
          doPop = 1'b1;
        end
        default: begin
          doPush = 1'b0;
        end
      endcase
    end
  end

  assign spPrev  = sp_ff - 3'h1;
  assign pcNext1 = pc_ff + 13'h0001;

  // A call returns past itself; an interrupt resumes the instruction it displaced.
  always_comb begin
    if (ctlReq.op == pcsia_pkg::OP_CALL) begin
      pushValue = pcNext1;
    end else begin
      pushValue = pc_ff;
    end
  end

  // Read data for direct registers; the stack pointer has no address.
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitPcl) begin
      rdMux = {24'h00_0000, pc_ff[7:0]};
    end else if (hitFsr) begin
      rdMux = {24'h00_0000, fsr_ff};
    end else if (hitHold) begin
      rdMux = {24'h00_0000, hold_ff};
    end else if (hitBank) begin
      rdMux = {24'h00_0000, bankBit_ff, 7'h00};
    end
  end

  // Next program counter; a decoder operation beats a bus write to the low register.
  always_comb begin
    nxt_pc = pc_ff;
    if (ctlReq.valid) begin
      case (ctlReq.op)
        pcsia_pkg::OP_NEXT: begin
          nxt_pc = pcNext1;
        end
        pcsia_pkg::OP_GOTO, pcsia_pkg::OP_CALL: begin
          nxt_pc = {hold_ff[pcsia_pkg::HOLD_CALL_HI:pcsia_pkg::HOLD_CALL_LO],
                    ctlReq.target};
        end
        pcsia_pkg::OP_RETURN, pcsia_pkg::OP_RETURN_WITH_LITERAL, pcsia_pkg::OP_RETURN_FROM_INTERRUPT: begin
          nxt_pc = stack_ff[spPrev];
        end
        pcsia_pkg::OP_IRQ: begin
          nxt_pc = IRQ_VECTOR;
        end
        default: begin
          nxt_pc = pc_ff;
        end
      endcase
    end else if (pclWrite) begin
      nxt_pc = {hold_ff[4:0], wb_dat_i[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_ff <= pcsia_pkg::PC_RESET;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Holding latch; stack traffic never touches it.
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_ff <= pcsia_pkg::HOLD_RESET;
    end else if (wrTake && hitHold) begin
      hold_ff <= wb_dat_i[7:0];
    end
  end

  // File select pointer.
  always_ff @(posedge clk) begin
    if (srst) begin
      fsr_ff <= pcsia_pkg::FSR_RESET;
    end else if (wrTake && hitFsr) begin
      fsr_ff <= wb_dat_i[7:0];
    end
  end

  // Bank bit is kept for software only; no address ever uses it.
  always_ff @(posedge clk) begin
    if (srst) begin
      bankBit_ff <= 1'b0;
    end else if (wrTake && hitBank) begin
      bankBit_ff <= wb_dat_i[pcsia_pkg::BANK_BIT_POS];
    end
  end

  // Stack pointer wraps modulo eight with no status kept.
  always_comb begin
    nxt_sp = sp_ff;
    if (doPush) begin
      nxt_sp = sp_ff + 3'h1;
    end else if (doPop) begin
      nxt_sp = spPrev;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sp_ff <= pcsia_pkg::SP_RESET;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // Stack entries.
  genvar gi;
  generate
    for (gi = 0; gi < pcsia_pkg::STACK_N; gi++) begin : g_stack
      always_ff @(posedge clk) begin
        if (srst) begin
          stack_ff[gi] <= pcsia_pkg::PC_RESET;
        end else if (doPush && sp_ff == SP_W'(gi)) begin
          stack_ff[gi] <= pushValue;
        end
      end
    end
  endgenerate

  // Bus sequencing; indirect reads go out to data memory and wait for it.
  always_comb begin
    nxt_busState = busState_ff;
    case (busState_ff)
      pcsia_pkg::BUS_IDLE: begin
        if (startRd) begin
          nxt_busState = pcsia_pkg::BUS_RD1;
        end
      end
      pcsia_pkg::BUS_RD1: begin
        nxt_busState = pcsia_pkg::BUS_RD2;
      end
      pcsia_pkg::BUS_RD2: begin
        nxt_busState = pcsia_pkg::BUS_IDLE;
      end
      default: begin
        nxt_busState = pcsia_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busState_ff <= pcsia_pkg::BUS_IDLE;
    end else begin
      busState_ff <= nxt_busState;
    end
  end

  // Memory strobes last one cycle per access.
  always_ff @(posedge clk) begin
    if (srst) begin
      memRe_ff <= 1'b0;
      memWe_ff <= 1'b0;
    end else begin
      memRe_ff <= startRd;
      memWe_ff <= indHit && wb_we_i && wb_sel_i[0];
    end
  end

  // Memory address and write data hold between accesses.
  always_ff @(posedge clk) begin
    if (srst) begin
      memAddr_ff  <= '0;
      memWdata_ff <= '0;
    end else if (indHit) begin
      memAddr_ff  <= indAddr;
      memWdata_ff <= wb_dat_i[7:0];
    end
  end

  // Acknowledge pulses for one cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      wbAck_ff <= 1'b0;
    end else begin
      wbAck_ff <= (busState_ff == pcsia_pkg::BUS_RD2) || (take && !startRd);
    end
  end

  // Read data stands until the next acknowledge.
  always_ff @(posedge clk) begin
    if (srst) begin
      wbDat_ff <= 32'h0000_0000;
    end else if (busState_ff == pcsia_pkg::BUS_RD2) begin
      wbDat_ff <= {24'h00_0000, memRdata};
    end else if (take && hitIndf && !startRd) begin
      wbDat_ff <= 32'h0000_0000;
    end else if (take && !startRd) begin
      wbDat_ff <= rdMux;
    end
  end

endmodule

// ==== sim/pcsia_core_chk.sv ====
`timescale 1ns/10ps
module pcsia_core_chk #(
  parameter logic [pcsia_pkg::PC_W-1:0] IRQ_VECTOR = 13'h0004
) (
  // Clock and reset.
  input wire logic                          clk,
  input wire logic                          srst,
  // Observed outputs and decoder input.
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          wb_ack_o,
  input wire pcsia_pkg::pcsia_ctl_t         ctlReq,
  input wire logic [pcsia_pkg::PC_W-1:0]    progCount,
  input wire pcsia_pkg::pcsia_mem_t         memReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic go;
  logic acc;
  assign go = ctlReq.valid;
  assign acc = memReq.re || memReq.we;
  a_reset_pc: assert property ($fell(srst) |-> progCount == 13'h0000)
    else $error("pc not zero after reset");
  a_goto_low: assert property (go && ctlReq.op == pcsia_pkg::OP_GOTO
    |=> progCount[10:0] == $past(ctlReq.target)) else $error("goto target lost");
  a_next_inc: assert property (go && ctlReq.op == pcsia_pkg::OP_NEXT
    |=> progCount == $past(progCount) + 13'h1) else $error("pc step wrong");
  a_irq_vec: assert property (go && ctlReq.op == pcsia_pkg::OP_IRQ
    |=> progCount == IRQ_VECTOR) else $error("irq vector wrong");
  a_call_ret: assert property ((go && ctlReq.op == pcsia_pkg::OP_CALL) ##1 !go
    ##1 (go && ctlReq.op == pcsia_pkg::OP_RETURN) |=> progCount == $past(progCount, 3) + 13'h1)
    else $error("return address wrong");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_rd_ack: assert property (memReq.re |=> !memReq.re ##1 wb_ack_o)
    else $error("indirect read ack late");
  a_bank_none: assert property (acc |-> memReq.addr[8] == 1'b0)
    else $error("bank bit used");
  a_no_self: assert property (acc |-> memReq.addr[7:0] != 8'h00)
    else $error("access through port itself");
  a_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  c_irq: cover property (go && ctlReq.op == pcsia_pkg::OP_IRQ);
  c_read: cover property (memReq.re);
  c_write: cover property (memReq.we);
endmodule
bind pcsia_core pcsia_core_chk #(.IRQ_VECTOR(IRQ_VECTOR)) u_chk (.clk(clk), .srst(srst),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctlReq(ctlReq), .progCount(progCount),
  .memReq(memReq));

// ==== sim/pcsia_dmem.sv ====
`timescale 1ns/10ps
module pcsia_dmem (
  // Clock.
  input wire logic                  clk,
  // Request and answer.
  input wire pcsia_pkg::pcsia_mem_t memReq,
  output logic [7:0]                memRdata
);
  logic [7:0] mem [512];
  logic [7:0] last = 8'h00;
  logic       rdNext = 1'b0;
  always @(posedge clk) begin
    rdNext <= memReq.re;
    if (memReq.we)
      mem[memReq.addr] <= memReq.wdata;
    if (memReq.re)
      last <= mem[memReq.addr];
  end
  // Outside the answer cycle the data is inverted so a mistimed sample shows up.
  assign memRdata = rdNext ? last : ~last;
endmodule

// ==== sim/pcsia_core_test.sv ====
`timescale 1ns/10ps
module pcsia_core_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbSel = 4'h1;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0;
  pcsia_pkg::pcsia_ctl_t ctl = '0;
  logic [31:0] datO;
  logic ack;
  logic [12:0] pc;
  pcsia_pkg::pcsia_mem_t mreq;
  logic [7:0] mrd;
  logic [7:0] rd;
  logic [12:0] ret [9];
  int error_cnt = 0;
  int samples_checked = 0;
  initial forever #10 clk = ~clk;
  pcsia_core dut (.clk(clk), .srst(srst), .wb_cyc_i(wbStb), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ack),
    .ctlReq(ctl), .progCount(pc), .memReq(mreq), .memRdata(mrd));
  pcsia_dmem mem (.clk(clk), .memReq(mreq), .memRdata(mrd));
  task automatic chk(string n, logic [12:0] s, logic [12:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = datO[7:0];
    wbStb <= 1'b0;
  endtask
  task automatic op(pcsia_pkg::pcsia_op_t o, logic [10:0] t);
    @(posedge clk);
    ctl <= {1'b1, o, t};
    @(posedge clk);
    ctl.valid <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("pc", pc, 13'h0);
    wb(1'b1, 8'h0c, 8'h15);
    wb(1'b1, 8'h04, 8'h34);
    #1;
    chk("pc", pc, 13'h1534);
    wb(1'b0, 8'h04, 8'h00);
    chk("pcl", {5'h0, rd}, 13'h34);
    op(pcsia_pkg::OP_GOTO, 11'h123);
    chk("goto", pc, 13'h1123);
    for (int i = 0; i < 9; i++) begin
      ret[i] = pc + 13'h1;
      op(pcsia_pkg::OP_CALL, 11'(i * 16));
    end
    for (int k = 1; k < 10; k++) begin
      op(pcsia_pkg::pcsia_op_t'(3'h4 + 3'(k % 3)), 11'h0);
      chk("pop", pc, ret[k == 9 ? 8 : 9 - k]);
    end
    wb(1'b0, 8'h0c, 8'h00);
    chk("hold", {5'h0, rd}, 13'h15);
    wbSel <= 4'h0;
    wb(1'b1, 8'h0c, 8'h1f);
    wbSel <= 4'h1;
    wb(1'b0, 8'h0c, 8'h00);
    chk("hold_sel", {5'h0, rd}, 13'h15);
    op(pcsia_pkg::OP_IRQ, 11'h0);
    chk("irq", pc, 13'h0004);
    op(pcsia_pkg::OP_CALL, 11'h40);
    op(pcsia_pkg::OP_RETURN, 11'h0);
    chk("ret", pc, 13'h0005);
    op(pcsia_pkg::OP_RETURN_FROM_INTERRUPT, 11'h0);
    chk("return_from_interrupt", pc, ret[8]);
    op(pcsia_pkg::OP_NEXT, 11'h0);
    chk("next", pc, ret[8] + 13'h1);
    wb(1'b1, 8'h10, 8'h80);
    wb(1'b1, 8'h08, 8'h20);
    wb(1'b1, 8'h00, 8'ha5);
    wb(1'b0, 8'h00, 8'h00);
    chk("ind", {5'h0, rd}, 13'ha5);
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b1, 8'h00, 8'h77);
    wb(1'b0, 8'h00, 8'h00);
    chk("self", {5'h0, rd}, 13'h0);
    wb(1'b0, 8'h14, 8'h00);
    chk("unmap", {5'h0, rd}, 13'h0);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("rst", pc, 13'h0);
    close_out();
  end
endmodule
